/* File: inc/tester_pkg.sv */
// Constants and carrier types for the memory read/write self-test engine.
// Assumes a memory controller with an Avalon-MM user port and 32-bit words.
// What this block does
// - Test logic runs on a 40 MHz clock; the controller's 330 MHz system clock is derived from 125 MHz.
// - Write and read-back passes cover the whole 512MB memory bank.
// - Write generated sequence everywhere, then read back and compare to regenerated copy.
// - Every memory read and write goes over the Avalon-MM user port.
// - Each start-button press regenerates control signals and, if init and calibration succeeded, launches a fresh run.
// - All three green LEDs are lit while the start button is held.
// - Heartbeat LED blinks continuously after release, showing the clock is alive.
// - Pass LED blinks after release only if init and calibration succeeded.
// - Clean run leaves pass LED steadily lit; failed run never steady on.
package tester_pkg;

  localparam int REF_CLK_MHZ = 125;
  localparam int SYS_CLK_MHZ = 330;
  localparam longint CLK_HZ = 40_000_000;

  localparam longint MEM_BYTES = 64'd536870912;
  localparam int DATA_W = 32;
  localparam int WORD_BYTES = DATA_W / 8;
  localparam int MEM_ADDR_W = $clog2(MEM_BYTES / WORD_BYTES);

  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYCLES = int'(CLK_HZ / 1000 * BLINK_HALF_MS);

  localparam logic [DATA_W-1:0] SEQ_SEED = 32'h1234_5678;
  localparam logic [DATA_W-1:0] SEQ_POLY = 32'h04c1_1db7;

  localparam logic [2:0] LEDS_ALL_ON = 3'h7;
  localparam int LED_RESET_BIT = 0;
  localparam int LED_PASS_BIT = 1;
  localparam int LED_HEART_BIT = 2;

  typedef struct packed {
    logic read;
    logic write;
    logic [MEM_ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } mem_req_t;

  typedef struct packed {
    logic waitrequest;
    logic readdatavalid;
    logic [DATA_W-1:0] readdata;
  } mem_rsp_t;

  typedef struct packed {
    logic init_done;
    logic cal_success;
  } ctl_status_t;

endpackage

/* File: logic/lpddr2_memory_rw_tester.sv */
// Self-test engine that fills the memory and verifies it on each button press, if init and calibration succeeded.
// Assumes ref_clk is the controller's user-side clock and all inputs are synchronous to it.
`timescale 1ns/1ps
`default_nettype none

module lpddr2_memory_rw_tester #(
  parameter int TEST_ADDR_W = tester_pkg::MEM_ADDR_W,
  parameter int BLINK_HALF = tester_pkg::BLINK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Operator button, low while pressed
  input wire logic start_button_n,
  // Controller status
  input wire tester_pkg::ctl_status_t ctl_status,
  // Avalon-MM user port
  output var tester_pkg::mem_req_t mem_req,
  input wire tester_pkg::mem_rsp_t mem_rsp,
  // Indicators
  output logic [2:0] green_indicator_bus
);
  import tester_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_NOCAL, ST_WRITE, ST_READ, ST_DRAIN, ST_DONE
  } run_state_t;

  localparam logic [MEM_ADDR_W-1:0] LAST_WORD = MEM_ADDR_W'((64'd1 << TEST_ADDR_W) - 64'd1);

  function automatic logic [DATA_W-1:0] seq_step(input logic [DATA_W-1:0] v);
    seq_step = {v[DATA_W-2:0], 1'b0} ^ (v[DATA_W-1] ? SEQ_POLY : '0);
  endfunction

  run_state_t state_reg;
  mem_req_t req_reg;
  logic [DATA_W-1:0] gen_reg;
  logic [DATA_W-1:0] chk_reg;
  logic [MEM_ADDR_W-1:0] chk_addr_reg;
  logic fail_reg;
  logic held_reg;
  logic blink_reg;
  logic [31:0] blink_cnt_reg;
  logic [2:0] led_reg;

  wire held = !start_button_n;
  wire released = held_reg && !held;
  wire cal_ok = ctl_status.init_done && ctl_status.cal_success;
  wire wr_taken = req_reg.write && !mem_rsp.waitrequest;
  wire rd_taken = req_reg.read && !mem_rsp.waitrequest;
  wire at_last = req_reg.address == LAST_WORD;
  wire checking = (state_reg == ST_READ) || (state_reg == ST_DRAIN);
  wire got_word = checking && mem_rsp.readdatavalid;
  wire mismatch = got_word && (mem_rsp.readdata != chk_reg);
  wire running = (state_reg == ST_WRITE) || checking;
  wire blink_wrap = blink_cnt_reg == 32'(BLINK_HALF - 1);

  wire pass_led = running ? blink_reg : (state_reg == ST_DONE) && !fail_reg;
  wire [2:0] led_next = held ? LEDS_ALL_ON : {blink_reg, pass_led, 1'b0};

  assign mem_req = req_reg;
  assign green_indicator_bus = led_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b0;
      led_reg <= '0;
      held_reg <= 1'b0;
    end else begin
      blink_cnt_reg <= blink_wrap ? '0 : blink_cnt_reg + 32'd1;
      blink_reg <= blink_wrap ? !blink_reg : blink_reg;
      led_reg <= led_next;
      held_reg <= held;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      req_reg <= '0;
      gen_reg <= '0;
      chk_reg <= '0;
      chk_addr_reg <= '0;
      fail_reg <= 1'b0;
    end else if (held) begin
      state_reg <= ST_IDLE;
      req_reg.read <= 1'b0;
      req_reg.write <= 1'b0;
      fail_reg <= 1'b0;
    end else if (released) begin
      if (cal_ok) begin
        state_reg <= ST_WRITE;
        req_reg.write <= 1'b1;
        req_reg.address <= '0;
        req_reg.writedata <= SEQ_SEED;
        gen_reg <= seq_step(SEQ_SEED);
        chk_reg <= SEQ_SEED;
        chk_addr_reg <= '0;
      end else begin
        state_reg <= ST_NOCAL;
      end
    end else begin
      case (state_reg)
        ST_WRITE: begin
          if (wr_taken && at_last) begin
            req_reg.write <= 1'b0;
            req_reg.read <= 1'b1;
            req_reg.address <= '0;
            state_reg <= ST_READ;
          end else if (wr_taken) begin
            req_reg.address <= req_reg.address + 1'b1;
            req_reg.writedata <= gen_reg;
            gen_reg <= seq_step(gen_reg);
          end
        end
        ST_READ: begin
          if (rd_taken && at_last) begin
            req_reg.read <= 1'b0;
            state_reg <= ST_DRAIN;
          end else if (rd_taken) begin
            req_reg.address <= req_reg.address + 1'b1;
          end
        end
        default: begin
          state_reg <= state_reg;
        end
      endcase
      if (got_word) begin
        chk_reg <= seq_step(chk_reg);
        chk_addr_reg <= chk_addr_reg + 1'b1;
        if (chk_addr_reg == LAST_WORD) begin
          state_reg <= ST_DONE;
        end
      end
      if (mismatch) begin
        fail_reg <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_release_ok;
    held_reg && start_button_n && cal_ok;
  endsequence

  sequence s_write_stalled;
    req_reg.write && mem_rsp.waitrequest && start_button_n;
  endsequence

  property p_held_leds;
    held |=> green_indicator_bus == LEDS_ALL_ON;
  endproperty
  a_held_leds: assert property (p_held_leds) else $error("LEDs not all lit while held");

  property p_heartbeat;
    start_button_n |=> green_indicator_bus[LED_HEART_BIT] == $past(blink_reg);
  endproperty
  a_heartbeat: assert property (p_heartbeat) else $error("Heartbeat LED wrong");

  property p_nocal_dark;
    (state_reg == ST_NOCAL) && start_button_n |=> !green_indicator_bus[LED_PASS_BIT];
  endproperty
  a_nocal_dark: assert property (p_nocal_dark) else $error("Pass LED lit without cal");

  property p_start_run;
    s_release_ok |=> req_reg.write && req_reg.address == '0 && state_reg == ST_WRITE;
  endproperty
  a_start_run: assert property (p_start_run) else $error("Run did not start");

  property p_write_hold;
    s_write_stalled |=> req_reg.write && $stable(req_reg.address) && $stable(req_reg.writedata);
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("Write changed under wait");

  property p_addr_step;
    wr_taken && !at_last && start_button_n |=> req_reg.address == $past(req_reg.address) + 1'b1;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("Write address skipped");

  property p_to_read;
    wr_taken && at_last && start_button_n |=> state_reg == ST_READ && req_reg.read;
  endproperty
  a_to_read: assert property (p_to_read) else $error("Read pass did not follow");

  property p_mismatch;
    mismatch && start_button_n |=> fail_reg;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("Mismatch not latched");

  property p_fail_keep;
    fail_reg && start_button_n |=> fail_reg;
  endproperty
  a_fail_keep: assert property (p_fail_keep) else $error("Failure dropped early");

  property p_pass_steady;
    ((state_reg == ST_DONE) && !fail_reg && start_button_n) [*2]
      |=> green_indicator_bus[LED_PASS_BIT];
  endproperty
  a_pass_steady: assert property (p_pass_steady) else $error("Pass LED not steady");

  property p_fail_dark;
    (state_reg == ST_DONE) && fail_reg && start_button_n |=> !green_indicator_bus[LED_PASS_BIT];
  endproperty
  a_fail_dark: assert property (p_fail_dark) else $error("Pass LED lit on failure");

endmodule

`default_nettype wire

/* File: bench/mem_slave_model.sv */
// Behavioural memory controller user port for the self-test engine.
// Assumes one clock, word addressing and a fixed three-cycle read latency.
`timescale 1ns/1ps
`default_nettype none

module mem_slave_model
  import tester_pkg::*;
#(
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Master side
  input wire tester_pkg::mem_req_t req,
  output tester_pkg::mem_rsp_t rsp,
  // Flips bit 0 of returned words while high
  input wire logic corrupt
);
  logic [DATA_W-1:0] mem_reg [2**AW];
  logic [DATA_W-1:0] d0_reg;
  logic [DATA_W-1:0] d1_reg;
  logic [1:0] vld_reg;
  wire take = (req.read | req.write) & ~rsp.waitrequest;

  // Stalls come at random so the master's hold behaviour is exercised.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
      vld_reg <= 2'h0;
    end else begin
      rsp.waitrequest <= ($urandom % 3) == 0;
      if (take && req.write) begin
        mem_reg[req.address[AW-1:0]] <= req.writedata;
      end
      vld_reg <= {vld_reg[0], take & req.read};
      d0_reg <= mem_reg[req.address[AW-1:0]] ^ {31'h0, corrupt};
      d1_reg <= d0_reg;
      rsp.readdatavalid <= vld_reg[1];
      // Idle read data inverts every cycle, so stale use shows up.
      rsp.readdata <= vld_reg[1] ? d1_reg : ~rsp.readdata;
    end
  end
endmodule

`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the memory self-test engine.
// Assumes a 16-word memory and a four-cycle blink half period.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import tester_pkg::*;
  localparam int AW = 4;
  localparam int BH = 4;
  localparam int WORDS = 2**AW;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic start_button_n = 1'b1;
  logic corrupt = 1'b0;
  ctl_status_t ctl_status = '1;
  mem_req_t mem_req;
  mem_rsp_t mem_rsp;
  logic [2:0] green_indicator_bus;
  logic [DATA_W-1:0] exp_q[$];
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  int rd_cnt = 0;
  int rd_issue = 0;

  always #12.5 ref_clk = ~ref_clk;

  lpddr2_memory_rw_tester #(.TEST_ADDR_W(AW), .BLINK_HALF(BH)) i_lpddr2_memory_rw_tester (
    .ref_clk(ref_clk), .rst(rst), .start_button_n(start_button_n), .ctl_status(ctl_status),
    .mem_req(mem_req), .mem_rsp(mem_rsp), .green_indicator_bus(green_indicator_bus));
  mem_slave_model #(.AW(AW)) i_mem_slave_model (
    .clk(ref_clk), .rst(rst), .req(mem_req), .rsp(mem_rsp), .corrupt(corrupt));

  task automatic check(string name, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Watcher: every accepted write is held against the oldest note, every read against the issue count.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 20000) begin
      err_total++;
      results();
    end else begin
      if (!rst && !mem_rsp.waitrequest && mem_req.write) begin
        check("wr_left", 1, exp_q.size() > 0);
        check("wr_addr", 32'(WORDS - exp_q.size()), mem_req.address);
        check("wr_data", exp_q.pop_front(), mem_req.writedata);
      end
      if (!rst && !mem_rsp.waitrequest && mem_req.read) begin
        check("rd_after_wr", 0, exp_q.size());
        check("rd_addr", 32'(rd_issue), mem_req.address);
        rd_issue++;
      end
      if (mem_rsp.readdatavalid) rd_cnt++;
    end
  end

  // Hold the button, then release it with the chosen controller status.
  task automatic press(bit cal_ok, bit bad);
    logic [DATA_W-1:0] v;
    @(posedge ref_clk) start_button_n <= 1'b0;
    repeat (1 + $urandom % 3) @(posedge ref_clk);
    #1 check("leds_held", LEDS_ALL_ON, green_indicator_bus);
    exp_q.delete();
    rd_issue = 0;
    rd_cnt = 0;
    v = SEQ_SEED;
    for (int k = 0; k < WORDS && cal_ok; k++) begin
      exp_q.push_back(v);
      v = {v[DATA_W-2:0], 1'b0} ^ (v[DATA_W-1] ? SEQ_POLY : '0);
    end
    @(posedge ref_clk) begin
      start_button_n <= 1'b1;
      ctl_status <= {cal_ok, cal_ok};
      corrupt <= bad;
    end
  endtask

  // Wait for the read-back, then watch the pass and heartbeat LEDs.
  task automatic watch(logic exp_pass, bit wait_run);
    int n = 0;
    int tog = 0;
    int ptog = 0;
    logic hb;
    logic pb = 1'b0;
    while (wait_run && rd_cnt < WORDS && n < 2000) begin
      @(posedge ref_clk);
      n++;
      #1 if (n > 3 && green_indicator_bus[LED_PASS_BIT] !== pb) ptog++;
      pb = green_indicator_bus[LED_PASS_BIT];
    end
    if (wait_run) check("pass_blink", 1, ptog > 1);
    repeat (3) @(posedge ref_clk);
    hb = green_indicator_bus[LED_HEART_BIT];
    repeat (2 * BH + 2) begin
      @(posedge ref_clk);
      #1 check("pass_led", exp_pass, green_indicator_bus[LED_PASS_BIT]);
      check("reset_led", 0, green_indicator_bus[LED_RESET_BIT]);
      if (green_indicator_bus[LED_HEART_BIT] !== hb) tog++;
      hb = green_indicator_bus[LED_HEART_BIT];
    end
    check("heartbeat", 1, tog > 1);
  endtask

  initial begin
    void'($urandom(32'h6feb));
    repeat (5) @(posedge ref_clk);
    check("leds_rst", 0, green_indicator_bus);
    rst <= 1'b0;
    press(1, 0);
    repeat (6) @(posedge ref_clk);
    press(1, 0);
    watch(1, 1);
    press(1, 1);
    watch(0, 1);
    press(1, 0);
    watch(1, 1);
    press(0, 0);
    watch(0, 0);
    results();
  end
endmodule

`default_nettype wire
